// File: rtl/cid_contact_debounce.sv
// What this block does
// - Sample every contact input together on a fixed 0.5 ms scan tick.
// - Raw level is input voltage compared against a threshold shared per four inputs.
// - New state accepted once held for debounce time; 2.5 ms means sixth sample.
// - Rising and falling transitions use the same procedure and debounce time.
// - A validated change updates the operand and, if enabled, logs an event.
// - Logged change carries the microsecond time of the run's first sample.
// - Protection passes run eight per cycle, pass length set by frequency tracking.
// - Operand takes the validated state at the start of the next pass.
// - Operand delay is debounce time plus at most one scan interval and one protection pass.
// - Closed operand is one for a closed contact; open operand for open.
// - With events enabled, every validated change of that input raises an event.
// - Installed modules found at startup decide which inputs exist and are settable.
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module cid_contact_debounce #(
  parameter int unsigned N_INPUTS = 16,
  parameter int unsigned SCAN_CYCLES = cid_pkg::SCAN_CYCLES,
  parameter int unsigned PASS_CYCLES = cid_pkg::PASS_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [N_INPUTS*cid_pkg::VOLT_W-1:0] input_voltage,
  input wire logic [N_INPUTS/cid_pkg::GROUP_SIZE-1:0] module_present,
  output logic [N_INPUTS-1:0] input_closed_operand,
  output logic [N_INPUTS-1:0] input_open_operand,
  output logic pass_start,
  output logic irq
);

  localparam int unsigned NG = N_INPUTS / cid_pkg::GROUP_SIZE;
  localparam int unsigned VW = cid_pkg::VOLT_W;
  localparam int unsigned SW = cid_pkg::STAMP_W;
  localparam logic [31:0] SCAN_LAST = 32'(SCAN_CYCLES - 1);
  localparam logic [cid_pkg::US_W-1:0] US_LAST = cid_pkg::US_W'(cid_pkg::STAMP_TICK_CYCLES - 1);

  // ***********************************************
  // Timebases
  // ***********************************************
  logic [31:0] scan_cnt;
  logic [cid_pkg::US_W-1:0] us_cnt;
  logic [SW-1:0] now_us;
  logic [cid_pkg::PASS_W-1:0] pass_cnt;
  logic [cid_pkg::PASS_W-1:0] pass_period;
  wire scan_tick = (scan_cnt == SCAN_LAST);
  wire pass_due = (pass_cnt >= pass_period - cid_pkg::PASS_W'(1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_cnt <= 32'h0000_0000;
      us_cnt <= '0;
      now_us <= '0;
      pass_cnt <= '0;
      pass_start <= 1'b0;
    end else begin
      scan_cnt <= scan_tick ? 32'h0000_0000 : scan_cnt + 32'h0000_0001;
      us_cnt <= (us_cnt == US_LAST) ? '0 : us_cnt + 1'b1;
      now_us <= (us_cnt == US_LAST) ? now_us + 1'b1 : now_us;
      pass_cnt <= pass_due ? '0 : pass_cnt + 1'b1;
      pass_start <= pass_due;
    end
  end

  // ***********************************************
  // Installed module detection
  // ***********************************************
  logic [NG-1:0] pres_sync1;
  logic [NG-1:0] pres_sync2;
  logic [NG-1:0] present_grp;
  logic [1:0] boot_cnt;
  logic [N_INPUTS-1:0] present;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pres_sync1 <= '0;
      pres_sync2 <= '0;
      present_grp <= '0;
      boot_cnt <= 2'h0;
    end else begin
      pres_sync1 <= module_present;
      pres_sync2 <= pres_sync1;
      boot_cnt <= (boot_cnt == cid_pkg::BOOT_DONE) ? boot_cnt : boot_cnt + 2'h1;
      if (boot_cnt == cid_pkg::BOOT_CAPTURE) begin
        present_grp <= pres_sync2;
      end
    end
  end

  // ***********************************************
  // Configuration registers and bus decode
  // ***********************************************
  cid_pkg::cid_bus_req_s dp;
  logic rd_done;
  logic [N_INPUTS*VW-1:0] threshold;
  logic [cid_pkg::DEB_W-1:0] input_debounce_time;
  logic [N_INPUTS-1:0] event_en;
  logic [N_INPUTS-1:0] irq_en;
  logic [N_INPUTS-1:0] status;
  logic [N_INPUTS-1:0] stable;
  logic [N_INPUTS-1:0] raw;
  logic [N_INPUTS-1:0] validate;
  logic [N_INPUTS-1:0] first_sample;
  logic [N_INPUTS-1:0][cid_pkg::DEB_W-1:0] run_cnt;
  logic [N_INPUTS-1:0][SW-1:0] first_stamp;
  logic [N_INPUTS-1:0][SW-1:0] event_stamp;

  wire take = hsel && htrans[1] && hready;
  wire rd_wait = dp.valid && !dp.write && !rd_done;
  wire wr_now = dp.valid && dp.write;
  localparam int unsigned OFS_W_T = cid_pkg::OFS_W;
  wire [OFS_W_T-1:0] a = dp.addr;
  wire wr_thr = wr_now && (a == cid_pkg::OFS_THRESHOLD);
  wire wr_deb = wr_now && (a == cid_pkg::OFS_DEBOUNCE);
  wire wr_evt = wr_now && (a == cid_pkg::OFS_EVENT_EN);
  wire wr_pass = wr_now && (a == cid_pkg::OFS_PASS_PERIOD);
  wire wr_clr = wr_now && (a == cid_pkg::OFS_CLEAR);
  wire wr_ien = wr_now && (a == cid_pkg::OFS_IRQ_EN);
  wire stamp_hit = (a[OFS_W_T-1:cid_pkg::STAMP_BASE_LSB] ==
                    cid_pkg::OFS_STAMP_BASE[OFS_W_T-1:cid_pkg::STAMP_BASE_LSB]);
  wire [cid_pkg::STAMP_IDX_W-1:0] stamp_idx = a[cid_pkg::STAMP_IDX_LSB +: cid_pkg::STAMP_IDX_W];
  wire [31:0] stamp_rd = (stamp_hit && (32'(stamp_idx) < N_INPUTS)) ? 32'(event_stamp[stamp_idx]) : 32'h0000_0000;
  wire [N_INPUTS-1:0] clr_mask = wr_clr ? hwdata[N_INPUTS-1:0] : '0;
  wire [31:0] rd_mux =
    (a == cid_pkg::OFS_THRESHOLD) ? 32'(threshold) :
    (a == cid_pkg::OFS_DEBOUNCE) ? 32'(input_debounce_time) :
    (a == cid_pkg::OFS_EVENT_EN) ? 32'(event_en) :
    (a == cid_pkg::OFS_PASS_PERIOD) ? 32'(pass_period) :
    (a == cid_pkg::OFS_STATUS) ? 32'(status) :
    (a == cid_pkg::OFS_IRQ_EN) ? 32'(irq_en) :
    (a == cid_pkg::OFS_OPERAND) ? 32'(input_closed_operand) :
    (a == cid_pkg::OFS_PRESENT) ? 32'(present) :
    (a == cid_pkg::OFS_NOW) ? 32'(now_us) : stamp_rd;

  assign hreadyout = !rd_wait;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp <= '0;
      rd_done <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      dp <= take ? {1'b1, hwrite && (hsize == cid_pkg::SIZE_WORD), haddr[OFS_W_T-1:0]} : (rd_wait ? dp : '0);
      rd_done <= rd_wait;
      if (rd_wait) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      threshold <= {N_INPUTS{cid_pkg::THRESHOLD_RST}} >> ((N_INPUTS - NG) * VW);
      input_debounce_time <= cid_pkg::DEBOUNCE_RST;
      event_en <= '0;
      irq_en <= '0;
      pass_period <= cid_pkg::PASS_W'(PASS_CYCLES);
    end else begin
      if (wr_thr) threshold <= (N_INPUTS*VW)'(hwdata[NG*VW-1:0]);
      if (wr_deb) input_debounce_time <= hwdata[cid_pkg::DEB_W-1:0];
      if (wr_evt) event_en <= hwdata[N_INPUTS-1:0] & present;
      if (wr_ien) irq_en <= hwdata[N_INPUTS-1:0] & present;
      if (wr_pass) pass_period <= hwdata[cid_pkg::PASS_W-1:0];
    end
  end

  // ***********************************************
  // Per-input compare and debounce
  // ***********************************************
  for (genvar i = 0; i < N_INPUTS; i++) begin : g_in
    wire [VW-1:0] volt = input_voltage[i*VW +: VW];
    wire [VW-1:0] thr = threshold[(i/cid_pkg::GROUP_SIZE)*VW +: VW];
    assign present[i] = present_grp[i/cid_pkg::GROUP_SIZE];
    assign raw[i] = present[i] && (volt >= thr);
    assign first_sample[i] = scan_tick && (raw[i] != stable[i]) && (run_cnt[i] == '0);
    assign validate[i] = scan_tick && (raw[i] != stable[i]) && (run_cnt[i] >= input_debounce_time);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stable <= '0;
      run_cnt <= '0;
      first_stamp <= '0;
      event_stamp <= '0;
    end else begin
      for (int i = 0; i < N_INPUTS; i++) begin
        if (scan_tick) begin
          run_cnt[i] <= (raw[i] == stable[i] || validate[i]) ? '0 : run_cnt[i] + 1'b1;
        end
        if (first_sample[i]) first_stamp[i] <= now_us;
        if (validate[i]) begin
          stable[i] <= raw[i];
          event_stamp[i] <= first_sample[i] ? now_us : first_stamp[i];
        end
      end
    end
  end

  // ***********************************************
  // Operands, events and interrupt
  // ***********************************************
  wire [N_INPUTS-1:0] event_set = validate & event_en;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_closed_operand <= '0;
      input_open_operand <= '0;
      status <= '0;
    end else begin
      if (pass_start) begin
        input_closed_operand <= stable & present;
        input_open_operand <= ~stable & present;
      end
      status <= (status & ~clr_mask) | event_set;
    end
  end

  assign irq = |(status & irq_en);

  // ***********************************************
  // Checks
  // ***********************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  scan_spacing_a: assert property (scan_tick |=> !scan_tick [*8])
    else $error("scan tick repeated too soon");
  group_compare_a: assert property (scan_tick && present[0] |-> raw[0] == (input_voltage[VW-1:0] >= threshold[VW-1:0]))
    else $error("raw level not from group threshold");
  run_accept_a: assert property (scan_tick && raw[0] != stable[0] && run_cnt[0] == input_debounce_time
    |=> stable[0] == $past(raw[0]))
    else $error("change not accepted after debounce run");
  state_on_scan_a: assert property ($changed(stable) |-> $past(scan_tick))
    else $error("state moved off the scan tick");
  stamp_first_a: assert property (validate[0] && !first_sample[0] |=> event_stamp[0] == $past(first_stamp[0]))
    else $error("stamp not from first sample");
  pass_only_a: assert property ($changed(input_closed_operand) |-> $past(pass_start))
    else $error("operand moved outside pass start");
  pass_follow_a: assert property (pass_start |=> input_closed_operand == $past(stable & present))
    else $error("operand missed validated state");
  open_closed_a: assert property (!(|(input_open_operand & input_closed_operand)) &&
    (((input_open_operand | input_closed_operand) == present) || ((input_open_operand | input_closed_operand) == '0)))
    else $error("open and closed operands disagree");
  event_raise_a: assert property (validate[0] && event_en[0] |=> status[0] ##1 status[0] || $past(clr_mask[0]))
    else $error("enabled change raised no event");
  run_restart_a: assert property (scan_tick && raw[0] == stable[0] |=> run_cnt[0] == '0 && $stable(stable[0]))
    else $error("run not restarted");
  absent_quiet_a: assert property (!present[0] |-> !input_closed_operand[0] && !event_en[0])
    else $error("absent input active");
  absent_raw_a: assert property (!present[0] |-> !raw[0] && !irq_en[0])
    else $error("absent input sensed");
  boot_hold_a: assert property (boot_cnt == cid_pkg::BOOT_DONE |=> $stable(present_grp))
    else $error("installed set moved after startup");

  // ***********************************************
  // Bus checks
  // ***********************************************
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  write_ready_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("error response seen");
  read_data_a: assert property (rd_wait |=> hrdata == $past(rd_mux))
    else $error("read data not loaded");
  status_read_a: assert property (rd_wait && a == cid_pkg::OFS_STATUS |=> hrdata == 32'($past(status)))
    else $error("status read wrong");
  stamp_read_a: assert property (rd_wait && a == cid_pkg::OFS_STAMP_BASE |=> hrdata == $past(event_stamp[0]))
    else $error("stamp read wrong");
  deb_write_a: assert property (wr_deb |=> input_debounce_time == $past(hwdata[cid_pkg::DEB_W-1:0]))
    else $error("debounce time not written");
  thr_write_a: assert property (wr_thr |=> threshold[VW-1:0] == $past(hwdata[VW-1:0]))
    else $error("threshold not written");
  period_write_a: assert property (wr_pass |=> pass_period == $past(hwdata[cid_pkg::PASS_W-1:0]))
    else $error("pass period not written");
  ien_write_a: assert property (wr_ien |=> irq_en == $past(hwdata[N_INPUTS-1:0] & present))
    else $error("interrupt enable not masked");

  // ***********************************************
  // Timebase checks
  // ***********************************************
  us_step_a: assert property (us_cnt == US_LAST |=> now_us == $past(now_us) + 1'b1)
    else $error("microsecond count missed");
  scan_count_a: assert property (!scan_tick |=> scan_cnt == $past(scan_cnt) + 32'h0000_0001)
    else $error("scan counter skipped");
  pass_pulse_a: assert property (pass_start && pass_period > cid_pkg::PASS_W'(1) |=> !pass_start)
    else $error("pass start longer than one cycle");
  scan_all_a: assert property (validate != '0 |-> scan_tick)
    else $error("input validated off the scan");

  // ***********************************************
  // Debounce and event checks
  // ***********************************************
  run_step_a: assert property (scan_tick && raw[0] != stable[0] && !validate[0]
    |=> run_cnt[0] == $past(run_cnt[0]) + 1'b1)
    else $error("run count not advanced");
  fall_accept_a: assert property (validate[0] && !raw[0] |=> !stable[0])
    else $error("falling change not accepted");
  first_stamp_a: assert property (first_sample[0] |=> first_stamp[0] == $past(now_us))
    else $error("first sample not stamped");
  operand_hold_a: assert property (!pass_start |=> $stable(input_open_operand))
    else $error("open operand moved outside pass start");
  status_sticky_a: assert property (status[0] && !clr_mask[0] |=> status[0])
    else $error("status bit lost");
  status_clear_a: assert property (clr_mask[0] && !event_set[0] |=> !status[0])
    else $error("status bit not cleared");
  set_wins_a: assert property (event_set[0] && clr_mask[0] |=> status[0])
    else $error("clear beat a new event");
  irq_level_a: assert property (status[0] && irq_en[0] |-> irq)
    else $error("enabled event raised no interrupt");

endmodule

`default_nettype wire

// File: shared/cid_pkg.sv
package cid_pkg;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SCAN_TIME_NS = 500000;
  localparam int unsigned SCAN_CYCLES = SCAN_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned STAMP_TICK_NS = 1000;
  localparam int unsigned STAMP_TICK_CYCLES = STAMP_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned PASS_TIME_NS = 2083333;
  localparam int unsigned PASS_CYCLES = PASS_TIME_NS / CLK_PERIOD_NS;

  // ***********************************************
  // Widths
  // ***********************************************
  localparam int unsigned GROUP_SIZE = 4;
  localparam int unsigned VOLT_W = 8;
  localparam int unsigned DEB_W = 8;
  localparam int unsigned PASS_W = 24;
  localparam int unsigned STAMP_W = 32;
  localparam int unsigned US_W = 8;
  localparam int unsigned OFS_W = 12;

  // ***********************************************
  // Register offsets
  // ***********************************************
  localparam logic [OFS_W-1:0] OFS_THRESHOLD = 12'h000;
  localparam logic [OFS_W-1:0] OFS_DEBOUNCE = 12'h004;
  localparam logic [OFS_W-1:0] OFS_EVENT_EN = 12'h008;
  localparam logic [OFS_W-1:0] OFS_PASS_PERIOD = 12'h00C;
  localparam logic [OFS_W-1:0] OFS_STATUS = 12'h010;
  localparam logic [OFS_W-1:0] OFS_CLEAR = 12'h014;
  localparam logic [OFS_W-1:0] OFS_IRQ_EN = 12'h018;
  localparam logic [OFS_W-1:0] OFS_OPERAND = 12'h01C;
  localparam logic [OFS_W-1:0] OFS_PRESENT = 12'h020;
  localparam logic [OFS_W-1:0] OFS_NOW = 12'h024;
  localparam logic [OFS_W-1:0] OFS_STAMP_BASE = 12'h040;
  localparam int unsigned STAMP_IDX_LSB = 2;
  localparam int unsigned STAMP_IDX_W = 4;
  localparam int unsigned STAMP_BASE_LSB = 6;

  // ***********************************************
  // Reset values and codes
  // ***********************************************
  localparam logic [VOLT_W-1:0] THRESHOLD_RST = 8'h21;
  localparam logic [DEB_W-1:0] DEBOUNCE_RST = 8'h05;
  localparam logic [1:0] TRANS_NONSEQ_BIT = 2'h2;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [1:0] BOOT_CAPTURE = 2'h2;
  localparam logic [1:0] BOOT_DONE = 2'h3;

  typedef struct packed {
    logic valid;
    logic write;
    logic [OFS_W-1:0] addr;
  } cid_bus_req_s;

endpackage

// File: verif/cid_field_contacts.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************************************
// Field contacts seen through group comparators
// ***********************************************
module cid_field_contacts #(
  parameter int unsigned N_INPUTS = 16,
  parameter logic [3:0] PRESENT_MASK = 4'h7
) (
  input wire logic [N_INPUTS-1:0] closed,
  input wire logic [7:0] lvl_on,
  input wire logic [7:0] lvl_off,
  output logic [N_INPUTS*8-1:0] input_voltage,
  output logic [N_INPUTS/4-1:0] module_present
);
  // Fixed set of installed modules
  assign module_present = PRESENT_MASK[N_INPUTS/4-1:0];
  // Closed contact puts source voltage on the input
  always_comb begin
    for (int i = 0; i < N_INPUTS; i++) begin
      input_voltage[i*8 +: 8] = closed[i] ? lvl_on : lvl_off;
    end
  end
endmodule
`default_nettype wire

// File: verif/cid_contact_debounce_test.sv
`timescale 1ns/1ps
`default_nettype none
module cid_contact_debounce_test;
  localparam int unsigned NI = 16;
  localparam int unsigned SC = 16;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, rd_phase, hreadyout, hresp, pass_start, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [7:0] lvl_on, lvl_off, thr;
  logic [NI-1:0] closed, closed_op, open_op;
  logic [NI*8-1:0] input_voltage;
  logic [NI/4-1:0] module_present;
  logic [31:0] exp_q[$];
  int mismatches = 0;
  int total_checks = 0;
  int n;
  logic ps;

  always #2.5 hclk = ~hclk;

  // ***********************************************
  // Design and field side
  // ***********************************************
  cid_contact_debounce #(.N_INPUTS(NI), .SCAN_CYCLES(SC), .PASS_CYCLES(40)) cid_contact_debounce_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .input_voltage(input_voltage), .module_present(module_present),
    .input_closed_operand(closed_op), .input_open_operand(open_op), .pass_start(pass_start), .irq(irq));
  cid_field_contacts #(.N_INPUTS(NI)) cid_field_contacts_i (
    .closed(closed), .lvl_on(lvl_on), .lvl_off(lvl_off), .input_voltage(input_voltage),
    .module_present(module_present));

  // ***********************************************
  // Helpers
  // ***********************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One single word transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_phase <= !w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_phase <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  // Cycles until the closed operand of input 0 reaches v
  task automatic wait_op(input logic v);
    n = 0;
    ps = 1'b0;
    while (closed_op[0] !== v && n < 300) begin
      ps = pass_start;
      @(posedge hclk);
      n++;
    end
  endtask

  // Read data checked against the oldest note
  always @(posedge hclk) begin
    if (rd_phase && hreadyout && exp_q.size() > 0) begin
      chk(hrdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    close_out();
  end

  // ***********************************************
  // Tests
  // ***********************************************
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    rd_phase = 1'b0;
    closed = '0;
    lvl_on = 8'h21;
    lvl_off = 8'h00;
    seed = 32'h0001_2EA3;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(cid_pkg::OFS_THRESHOLD, 32'h2121_2121);
    rd(cid_pkg::OFS_DEBOUNCE, {24'h00_0000, cid_pkg::DEBOUNCE_RST});
    rd(cid_pkg::OFS_PRESENT, 32'h0000_0FFF);
    rd(12'h0FC, 32'h0000_0000);
    wr(cid_pkg::OFS_PASS_PERIOD, 32'h0000_0028);
    wr(cid_pkg::OFS_EVENT_EN, 32'h0000_FFFF);
    wr(cid_pkg::OFS_IRQ_EN, 32'h0000_0001);
    $display("test reset values done");
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      thr = 8'h11 + 8'(seed % 150);
      wr(cid_pkg::OFS_THRESHOLD, {thr, thr, thr, thr});
      lvl_on <= thr;
      lvl_off <= thr - 8'h01;
      closed <= 16'h1001;
      repeat (4 * SC) @(posedge hclk);
      chk(32'(closed_op[0]), 32'h0000_0000);
      wait_op(1'b1);
      chk(32'((4 * SC + n) >= 5 * SC && (4 * SC + n) <= 6 * SC + 42), 32'h0000_0001);
      chk(32'(ps), 32'h0000_0001);
      chk(32'({closed_op[12], closed_op[0], open_op[0]}), 32'h0000_0002);
      chk(32'(irq), 32'h0000_0001);
      rd(cid_pkg::OFS_STATUS, 32'h0000_0001);
      wr(cid_pkg::OFS_CLEAR, 32'h0000_0001);
      rd(cid_pkg::OFS_STATUS, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      closed <= 16'h0000;
      repeat (3 * SC) @(posedge hclk);
      closed <= 16'h1001;
      repeat (10 * SC) @(posedge hclk);
      chk(32'(closed_op[0]), 32'h0000_0001);
      rd(cid_pkg::OFS_STATUS, 32'h0000_0000);
      closed <= 16'h0000;
      repeat (4 * SC) @(posedge hclk);
      chk(32'(closed_op[0]), 32'h0000_0001);
      wait_op(1'b0);
      chk(32'((4 * SC + n) >= 5 * SC && (4 * SC + n) <= 6 * SC + 42), 32'h0000_0001);
      chk(32'(open_op[0]), 32'h0000_0001);
      rd(cid_pkg::OFS_STATUS, 32'h0000_0001);
      wr(cid_pkg::OFS_CLEAR, 32'h0000_0001);
      $display("test threshold %0d done", thr);
    end
    close_out();
  end
endmodule
`default_nettype wire
